// ### dv/lcg_top_asserts.sv
// Port checker for lcg_top: shadows committed APB writes, then ties outputs to causes.
// Assumes it is bound to lcg_top and that every register clears while presetn is low.
`timescale 1ns/1ns
module lcg_top_asserts #(
    parameter logic [63:0] SOURCE_MASK = 64'hffff_ffff_ffff_ffff
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [63:0] sources,
    input wire logic        selected_data_in_1,
    input wire logic        selected_data_in_2,
    input wire logic        selected_data_in_3,
    input wire logic        selected_data_in_4,
    input wire logic        gate0_out,
    input wire logic        gate1_out
);
    logic [7:0] sh [0:7];
    logic [3:0] ed;
    logic [3:0] d;
    logic [7:0] t;
    logic       acc;
    logic       bad;
    logic       g0;
    logic       g1;
    assign acc = psel && penable;
    assign bad = |paddr[11:5];
    assign d = {selected_data_in_4, selected_data_in_3, selected_data_in_2, selected_data_in_1};
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            ed[k] = sources[sh[k][5:0]] & SOURCE_MASK[sh[k][5:0]];
            t[2*k+1] = d[k];
            t[2*k] = ~d[k];
        end
        g0 = (|(sh[4] & t)) ^ sh[6][0];
        g1 = (|(sh[5] & t)) ^ sh[6][1];
    end
    // Shadow keeps only implemented bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh <= '{default: 8'h00};
        end else if (acc && pwrite && pstrb[0] && !bad && paddr[4:2] != 3'h7) begin
            sh[paddr[4:2]] <= pwdata[7:0] & (paddr[4] ? (paddr[3] ? 8'h03 : 8'hff) : 8'h3f);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready; acc |-> pready; endproperty
    property p_idle; !acc |-> prdata == 32'h0 && !pslverr; endproperty
    property p_err; acc |-> pslverr == bad; endproperty
    property p_rd;
        acc && !pwrite && !bad && paddr[4:2] != 3'h7 |-> prdata == {24'h0, sh[paddr[4:2]]};
    endproperty
    property p_sel(k, logic s); $past(presetn) |-> s == $past(ed[k]); endproperty
    property p_g0; $past(presetn) |-> gate0_out == $past(g0); endproperty
    property p_g1; $past(presetn) |-> gate1_out == $past(g1); endproperty
    a_ready: assert property (p_ready) else $error("pready low in access");
    a_idle: assert property (p_idle) else $error("bus outputs not idle");
    a_err: assert property (p_err) else $error("pslverr wrong for address");
    a_rd: assert property (p_rd) else $error("read data wrong");
    a_sel1: assert property (p_sel(0, selected_data_in_1)) else $error("data 1 wrong");
    a_sel2: assert property (p_sel(1, selected_data_in_2)) else $error("data 2 wrong");
    a_sel3: assert property (p_sel(2, selected_data_in_3)) else $error("data 3 wrong");
    a_sel4: assert property (p_sel(3, selected_data_in_4)) else $error("data 4 wrong");
    a_g0: assert property (p_g0) else $error("gate 0 wrong");
    a_g1: assert property (p_g1) else $error("gate 1 wrong");
    c_wr: cover property (acc && pwrite);
    c_bad: cover property (acc && bad);
    c_g: cover property (gate0_out && gate1_out);
endmodule : lcg_top_asserts

bind lcg_top lcg_top_asserts #(.SOURCE_MASK(SOURCE_MASK)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sources(sources), .selected_data_in_1(selected_data_in_1),
    .selected_data_in_2(selected_data_in_2), .selected_data_in_3(selected_data_in_3),
    .selected_data_in_4(selected_data_in_4), .gate0_out(gate0_out), .gate1_out(gate1_out)
);

// ### dv/lcg_top_tb.sv
// Self-checking bench for lcg_top: APB register tests, source routing, gate terms.
// Assumes zero-wait APB answers may come; waits on pready under a bound anyway.
`timescale 1ns/1ns
module lcg_top_tb;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [63:0] sources;
    logic [3:0]  d;
    logic [1:0]  g;
    logic [7:0]  en;
    int          bad_count;
    int          check_count;
    logic [7:0]  msk [0:6] = '{8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'hff, 8'hff, 8'h03};

    // Code 63 has no source behind it
    lcg_top #(.SOURCE_MASK(64'h7fff_ffff_ffff_ffff)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sources(sources), .selected_data_in_1(d[0]),
        .selected_data_in_2(d[1]), .selected_data_in_3(d[2]), .selected_data_in_4(d[3]),
        .gate0_out(g[0]), .gate1_out(g[1])
    );

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic apb(input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st,
                       input logic wr, output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (pready !== 1'b1) begin
            bad_count++;
            end_sim();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st);
        logic [31:0] rd;
        logic        er;
        apb(a, wd, st, 1'b1, rd, er);
    endtask : wr

    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e,
                       input logic ee);
        logic [31:0] rd;
        logic        er;
        apb(a, 32'h0, 4'h0, 1'b0, rd, er);
        chk(nm, e, rd);
        chk("pslverr", {31'h0, ee}, {31'h0, er});
    endtask : rdc

    function automatic logic gexp(input logic [3:0] dv, input logic [7:0] e, input logic p);
        logic [7:0] t;
        for (int k = 0; k < 4; k++) begin
            t[2*k+1] = dv[k];
            t[2*k] = ~dv[k];
        end
        return (|(e & t)) ^ p;
    endfunction : gexp

    task end_sim;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    initial begin
        #200000;
        bad_count++;
        end_sim();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        sources = 64'hc000_0000_0000_0004;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 7; i++) begin
            wr(12'(4 * i), 32'hffff_ffff, 4'hf);
            rdc("reg ones", 12'(4 * i), {24'h0, msk[i]}, 1'b0);
            wr(12'(4 * i), 32'h0, 4'he);
            rdc("reg strobe", 12'(4 * i), {24'h0, msk[i]}, 1'b0);
        end
        rdc("unmapped", 12'h020, 32'h0, 1'b1);
        $display("test registers done");
        wr(12'h000, 32'h1, 4'hf);
        wr(12'h004, 32'h2, 4'hf);
        wr(12'h008, 32'h3e, 4'hf);
        wr(12'h00c, 32'h3f, 4'hf);
        repeat (3) @(posedge pclk);
        chk("data", 32'h6, {28'h0, d});
        sources[1] <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("data", 32'h7, {28'h0, d});
        $display("test routing done");
        for (int b = 0; b < 9; b++) begin
            en = 8'(9'h1 << b);
            wr(12'h010, {24'h0, en}, 4'hf);
            wr(12'h014, {24'h0, 8'h80 >> b}, 4'hf);
            wr(12'h018, 32'(b % 4), 4'hf);
            repeat (3) @(posedge pclk);
            chk("gate0", {31'h0, gexp(4'h7, en, b[0])}, {31'h0, g[0]});
            chk("gate1", {31'h0, gexp(4'h7, 8'h80 >> b, b[1])}, {31'h0, g[1]});
        end
        rdc("status", 12'h01c, 32'h07, 1'b0);
        $display("test gates done");
        end_sim();
    end
endmodule : lcg_top_tb

// ### include/lcg_pkg.sv
// Package for the logic cell input gate select block.
// Assumes a 32-bit APB slave on pclk; register map, fields and reset values live here.
package lcg_pkg;

    // Bus geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // Register byte addresses
    localparam logic [11:0] DATA1_SOURCE_SELECT_ADDR = 12'h000;
    localparam logic [11:0] DATA2_SOURCE_SELECT_ADDR = 12'h004;
    localparam logic [11:0] DATA3_SOURCE_SELECT_ADDR = 12'h008;
    localparam logic [11:0] DATA4_SOURCE_SELECT_ADDR = 12'h00c;
    localparam logic [11:0] GATE0_INPUT_ENABLE_ADDR  = 12'h010;
    localparam logic [11:0] GATE1_INPUT_ENABLE_ADDR  = 12'h014;
    localparam logic [11:0] POLARITY_REGISTER_ADDR   = 12'h018;
    localparam logic [11:0] INPUT_STATUS_ADDR        = 12'h01c;

    // Field layout
    localparam int unsigned CODE_W       = 6;
    localparam int unsigned SOURCE_COUNT = 64;
    localparam int unsigned ENABLE_W     = 8;
    localparam int unsigned DATA_COUNT   = 4;
    localparam int unsigned GATE_COUNT   = 2;

    // Polarity register bits
    localparam int unsigned GATE0_INVERT_BIT = 0;
    localparam int unsigned GATE1_INVERT_BIT = 1;

    // Input status register fields
    localparam int unsigned STATUS_DATA_LSB = 0;
    localparam int unsigned STATUS_GATE_LSB = 4;

    // Byte lane holding every implemented register bit
    localparam int unsigned WRITE_LANE = 0;

    // Stand-in power-on values for bits that are undefined at power-on
    localparam logic [5:0] CODE_RESET   = 6'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic       INVERT_RESET = 1'b0;

    // Reads of unmapped addresses and of unimplemented bits
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // Complete state of the top module
    typedef struct packed {
        logic [5:0]  data1_source_code;
        logic [5:0]  data2_source_code;
        logic [5:0]  data3_source_code;
        logic [5:0]  data4_source_code;
        logic [7:0]  gate0_input_enable;
        logic [7:0]  gate1_input_enable;
        logic        gate0_invert;
        logic        gate1_invert;
        logic [3:0]  selected_data;
        logic [1:0]  gate_out;
        logic [31:0] rdata;
        logic        rerr;
    } lcg_state_t;

endpackage : lcg_pkg

// ### rtl/lcg_gate.sv
// One input gate of the logic cell: enabled true/inverted data ORed, then polarity.
// Assumes the four selected data inputs and the enable byte come from flip-flops.
`timescale 1ns/1ns
module lcg_gate (
    input  wire logic [3:0] data_in,
    input  wire logic [7:0] input_enable,
    input  wire logic       invert,
    output logic            gate_out
);

    logic [3:0] true_terms;
    logic [3:0] inv_terms;
    logic       ored;

    always_comb begin
        for (int k = 0; k < 4; k++) begin
            true_terms[k] = data_in[k] & input_enable[2*k+1];
            inv_terms[k]  = ~data_in[k] & input_enable[2*k];
        end
        // clear bits keep a term out; OR, zero when none set
        ored = |{true_terms, inv_terms};
        gate_out = ored ^ invert;
    end

endmodule : lcg_gate

// ### rtl/lcg_top.sv
// Input selection front end of a configurable logic cell, with its APB register file.
// Assumes a 32-bit APB master on pclk, and on-chip sources synchronous to pclk.
`timescale 1ns/1ns
module lcg_top #(
    // Set bit n when source code n has a signal behind it
    parameter logic [63:0] SOURCE_MASK = 64'hffff_ffff_ffff_ffff
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [63:0] sources,
    output logic             selected_data_in_1,
    output logic             selected_data_in_2,
    output logic             selected_data_in_3,
    output logic             selected_data_in_4,
    output logic             gate0_out,
    output logic             gate1_out
);

    lcg_pkg::lcg_state_t st;
    lcg_pkg::lcg_state_t next_st;

    logic        setup_phase;
    logic        access_phase;
    logic        write_take;
    logic        lane_on;
    logic [7:0]  wbyte;
    logic [11:0] word_addr;
    logic [1:0]  gate_comb;
    logic        wr_data1;
    logic        wr_data2;
    logic        wr_data3;
    logic        wr_data4;
    logic        wr_gate0;
    logic        wr_gate1;
    logic        wr_polarity;

    // ------------------------------------------------------------------
    // Source picking
    // ------------------------------------------------------------------

    function automatic logic pick_source(
        input logic [63:0] src,
        input logic [5:0]  code
    );
        logic present;
        present = SOURCE_MASK[code];
        return src[code] & present;
    endfunction : pick_source

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------

    function automatic logic is_mapped(input logic [11:0] addr);
        logic hit;
        hit = 1'b0;
        unique case (addr)
            lcg_pkg::DATA1_SOURCE_SELECT_ADDR,
            lcg_pkg::DATA2_SOURCE_SELECT_ADDR,
            lcg_pkg::DATA3_SOURCE_SELECT_ADDR,
            lcg_pkg::DATA4_SOURCE_SELECT_ADDR,
            lcg_pkg::GATE0_INPUT_ENABLE_ADDR,
            lcg_pkg::GATE1_INPUT_ENABLE_ADDR,
            lcg_pkg::POLARITY_REGISTER_ADDR,
            lcg_pkg::INPUT_STATUS_ADDR: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction : is_mapped

    // ------------------------------------------------------------------
    // Read value of each register
    // ------------------------------------------------------------------

    function automatic logic [31:0] read_value(
        input lcg_pkg::lcg_state_t s,
        input logic [11:0]         addr
    );
        logic [31:0] v;
        v = lcg_pkg::READ_ZERO;
        unique case (addr)
            // upper select bits read as zero
            lcg_pkg::DATA1_SOURCE_SELECT_ADDR: begin
                v[lcg_pkg::CODE_W-1:0] = s.data1_source_code;
            end
            lcg_pkg::DATA2_SOURCE_SELECT_ADDR: begin
                v[lcg_pkg::CODE_W-1:0] = s.data2_source_code;
            end
            lcg_pkg::DATA3_SOURCE_SELECT_ADDR: begin
                v[lcg_pkg::CODE_W-1:0] = s.data3_source_code;
            end
            lcg_pkg::DATA4_SOURCE_SELECT_ADDR: begin
                v[lcg_pkg::CODE_W-1:0] = s.data4_source_code;
            end
            lcg_pkg::GATE0_INPUT_ENABLE_ADDR: begin
                v[lcg_pkg::ENABLE_W-1:0] = s.gate0_input_enable;
            end
            lcg_pkg::GATE1_INPUT_ENABLE_ADDR: begin
                v[lcg_pkg::ENABLE_W-1:0] = s.gate1_input_enable;
            end
            lcg_pkg::POLARITY_REGISTER_ADDR: begin
                v[lcg_pkg::GATE0_INVERT_BIT] = s.gate0_invert;
                v[lcg_pkg::GATE1_INVERT_BIT] = s.gate1_invert;
            end
            lcg_pkg::INPUT_STATUS_ADDR: begin
                v[lcg_pkg::STATUS_DATA_LSB +: lcg_pkg::DATA_COUNT] = s.selected_data;
                v[lcg_pkg::STATUS_GATE_LSB +: lcg_pkg::GATE_COUNT] = s.gate_out;
            end
            default: begin
                v = lcg_pkg::READ_ZERO;
            end
        endcase
        return v;
    endfunction : read_value

    // ------------------------------------------------------------------
    // Gates
    // ------------------------------------------------------------------

    // gate 0 from its enable byte
    lcg_gate u_gate0 (
        .data_in      (st.selected_data),
        .input_enable (st.gate0_input_enable),
        .invert       (st.gate0_invert),
        .gate_out     (gate_comb[0])
    );

    // gate 1 from its enable byte
    lcg_gate u_gate1 (
        .data_in      (st.selected_data),
        .input_enable (st.gate1_input_enable),
        .invert       (st.gate1_invert),
        .gate_out     (gate_comb[1])
    );

    // ------------------------------------------------------------------
    // Bus phases
    // ------------------------------------------------------------------

    always_comb begin
        setup_phase  = psel & ~penable;
        access_phase = psel & penable;
        write_take   = access_phase & pwrite;
        lane_on      = pstrb[lcg_pkg::WRITE_LANE];
        wbyte        = pwdata[8*lcg_pkg::WRITE_LANE +: 8];
        word_addr    = {paddr[11:2], 2'b00};
    end

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------

    // One strobe per writable register; the status word and holes take no write
    always_comb begin
        wr_data1    = 1'b0;
        wr_data2    = 1'b0;
        wr_data3    = 1'b0;
        wr_data4    = 1'b0;
        wr_gate0    = 1'b0;
        wr_gate1    = 1'b0;
        wr_polarity = 1'b0;
        // Only byte lane 0 carries implemented bits
        if (write_take && lane_on) begin
            unique case (word_addr)
                lcg_pkg::DATA1_SOURCE_SELECT_ADDR: begin
                    wr_data1 = 1'b1;
                end
                lcg_pkg::DATA2_SOURCE_SELECT_ADDR: begin
                    wr_data2 = 1'b1;
                end
                lcg_pkg::DATA3_SOURCE_SELECT_ADDR: begin
                    wr_data3 = 1'b1;
                end
                lcg_pkg::DATA4_SOURCE_SELECT_ADDR: begin
                    wr_data4 = 1'b1;
                end
                lcg_pkg::GATE0_INPUT_ENABLE_ADDR: begin
                    wr_gate0 = 1'b1;
                end
                lcg_pkg::GATE1_INPUT_ENABLE_ADDR: begin
                    wr_gate1 = 1'b1;
                end
                lcg_pkg::POLARITY_REGISTER_ADDR: begin
                    wr_polarity = 1'b1;
                end
                default: begin
                    wr_polarity = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------

    always_comb begin
        next_st = st;

        // Read data and error are captured in the setup cycle, so the access
        // cycle answers at once; they fall back to zero at every other edge
        if (setup_phase) begin
            next_st.rerr = ~is_mapped(word_addr);
            if (pwrite) begin
                next_st.rdata = lcg_pkg::READ_ZERO;
            end else begin
                next_st.rdata = read_value(st, word_addr);
            end
        end else begin
            next_st.rdata = lcg_pkg::READ_ZERO;
            next_st.rerr  = 1'b0;
        end

        // Writes take effect at the edge that ends the access phase
        // data 1 code; bits 7 and 6 dropped
        if (wr_data1) begin
            next_st.data1_source_code = wbyte[lcg_pkg::CODE_W-1:0];
        end
        if (wr_data2) begin
            next_st.data2_source_code = wbyte[lcg_pkg::CODE_W-1:0];
        end
        if (wr_data3) begin
            next_st.data3_source_code = wbyte[lcg_pkg::CODE_W-1:0];
        end
        if (wr_data4) begin
            next_st.data4_source_code = wbyte[lcg_pkg::CODE_W-1:0];
        end
        if (wr_gate0) begin
            next_st.gate0_input_enable = wbyte;
        end
        if (wr_gate1) begin
            next_st.gate1_input_enable = wbyte;
        end
        if (wr_polarity) begin
            next_st.gate0_invert = wbyte[lcg_pkg::GATE0_INVERT_BIT];
            next_st.gate1_invert = wbyte[lcg_pkg::GATE1_INVERT_BIT];
        end

        next_st.selected_data[0] = pick_source(sources, st.data1_source_code);
        next_st.selected_data[1] = pick_source(sources, st.data2_source_code);
        next_st.selected_data[2] = pick_source(sources, st.data3_source_code);
        next_st.selected_data[3] = pick_source(sources, st.data4_source_code);

        // Gate results after polarity
        next_st.gate_out = gate_comb;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    // presetn clears every field here, select bits included; APB writes to lane 0 also change them
    // Zero stands in for the undefined power-on value; software writes before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st.data1_source_code  <= lcg_pkg::CODE_RESET;
            st.data2_source_code  <= lcg_pkg::CODE_RESET;
            st.data3_source_code  <= lcg_pkg::CODE_RESET;
            st.data4_source_code  <= lcg_pkg::CODE_RESET;
            st.gate0_input_enable <= lcg_pkg::ENABLE_RESET;
            st.gate1_input_enable <= lcg_pkg::ENABLE_RESET;
            st.gate0_invert       <= lcg_pkg::INVERT_RESET;
            st.gate1_invert       <= lcg_pkg::INVERT_RESET;
            st.selected_data      <= '0;
            st.gate_out           <= '0;
            st.rdata              <= lcg_pkg::READ_ZERO;
            st.rerr               <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // Zero wait states: the answer stands for the whole access cycle
    always_comb begin
        pready             = access_phase;
        prdata             = st.rdata;
        pslverr            = access_phase & st.rerr;
    end

    // ------------------------------------------------------------------
    // Data path outputs
    // ------------------------------------------------------------------

    always_comb begin
        selected_data_in_1 = st.selected_data[0];
        selected_data_in_2 = st.selected_data[1];
        selected_data_in_3 = st.selected_data[2];
        selected_data_in_4 = st.selected_data[3];
        gate0_out          = st.gate_out[0];
        gate1_out          = st.gate_out[1];
    end

endmodule : lcg_top
